/* File: hw/ept_port.sv */
// per-port tlp end-to-end parity, lcrc nullify, error report and attribute forcing
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`include "ept_defines.svh"
module ept_port
    import ept_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // ingress from link after lcrc check
    input wire logic rx_valid,
    input wire logic rx_sop,
    input wire logic rx_eop,
    input wire logic [31:0] rx_data,
    input wire logic rx_lcrc_bad,
    output logic rx_retry_req,
    // ingress to switch core
    output logic ig_valid,
    output logic ig_sop,
    output logic ig_eop,
    output logic [31:0] ig_data,
    output logic ig_par,
    // switch-produced tlps
    input wire logic gn_valid,
    input wire logic gn_sop,
    input wire logic gn_eop,
    input wire logic [31:0] gn_data,
    output logic gp_valid,
    output logic gp_sop,
    output logic gp_eop,
    output logic [31:0] gp_data,
    output logic gp_par,
    // tlps consumed by the switch
    input wire logic cs_valid,
    input wire logic cs_eop,
    input wire logic [31:0] cs_data,
    input wire logic cs_par,
    output logic cs_drop,
    // egress from core with stored parity
    input wire logic eg_valid,
    input wire logic eg_sop,
    input wire logic eg_eop,
    input wire logic [31:0] eg_data,
    input wire logic eg_par,
    output logic tx_valid,
    output logic tx_sop,
    output logic tx_eop,
    output logic [31:0] tx_data,
    output logic [31:0] tx_lcrc,
    output logic tx_edb,
    // error message request
    output logic err_msg_valid,
    output logic [1:0] err_msg_type
);

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    function automatic logic [31:0] crc_dw(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--)
        begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ `EPT_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic attr_ok(input logic [31:0] h);
        logic [3:0] t;
        t = h[`EPT_HDR_TYPE_HI:`EPT_HDR_TYPE_LO];
        return (t == `EPT_TYPE_MEM) || (t == `EPT_TYPE_CPL);
    endfunction

    //------------------------------------------------------------
    // control registers
    //------------------------------------------------------------
    logic chk_dis_reg;
    logic inject_reg;
    logic [9:0] inj_len_reg;
    logic [1:0] rep_ctl_reg;
    logic fro_reg;
    logic rov_reg;
    logic fns_reg;
    logic nsv_reg;
    logic flag_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic ack_reg;
    logic [31:0] wmask;
    logic wr_go;
    logic rd_go;
    logic err_evt;
    logic sts_clr;
    logic cnt_rd;
    logic sel_attr;
    logic [3:0] ofs;

    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_go = avs_write & ack_reg;
    assign rd_go = avs_read & ~ack_reg;
    assign sel_attr = avs_address[4] == `EPT_PAGE_ATTR;
    // word address to byte offset; words 4..15 of a page land on unused offsets
    assign ofs = {avs_address[1:0], avs_address[3:2]};
    assign sts_clr = wr_go & ~sel_attr & (ofs == `EPT_OFS_STS)
                   & avs_writedata[`EPT_STS_FLAG] & avs_byteenable[0];
    assign cnt_rd = rd_go & ~sel_attr & (ofs == `EPT_OFS_CNT);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            chk_dis_reg <= 1'b0;
            inject_reg <= 1'b0;
            inj_len_reg <= '0;
            rep_ctl_reg <= `EPT_RCTL_RST;
            fro_reg <= 1'b0;
            rov_reg <= 1'b0;
            fns_reg <= 1'b0;
            nsv_reg <= 1'b0;
        end
        else if (wr_go && !sel_attr && ofs == `EPT_OFS_PCTL)
        begin
            if (avs_byteenable[0])
            begin
                chk_dis_reg <= avs_writedata[`EPT_PCTL_DIS];
                inject_reg <= avs_writedata[`EPT_PCTL_INJ];
            end
            inj_len_reg <= (inj_len_reg & ~wmask[`EPT_PCTL_LEN_HI:`EPT_PCTL_LEN_LO])
                | (avs_writedata[`EPT_PCTL_LEN_HI:`EPT_PCTL_LEN_LO]
                & wmask[`EPT_PCTL_LEN_HI:`EPT_PCTL_LEN_LO]);
        end
        else if (wr_go && !sel_attr && ofs == `EPT_OFS_RCTL && avs_byteenable[0])
            rep_ctl_reg <= avs_writedata[1:0];
        else if (wr_go && sel_attr && ofs == `EPT_OFS_ACTL && avs_byteenable[0])
        begin
            fro_reg <= avs_writedata[`EPT_ACTL_FRO];
            rov_reg <= avs_writedata[`EPT_ACTL_ROV];
            fns_reg <= avs_writedata[`EPT_ACTL_FNS];
            nsv_reg <= avs_writedata[`EPT_ACTL_NSV];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            avs_readdata <= '0;
        else if (rd_go)
        begin
            avs_readdata <= '0;
            if (sel_attr)
            begin
                if (ofs == `EPT_OFS_ACTL)
                    avs_readdata[3:0] <= {nsv_reg, fns_reg, rov_reg, fro_reg};
            end
            else
            begin
                case (ofs)
                    `EPT_OFS_PCTL:
                    begin
                        avs_readdata[`EPT_PCTL_DIS] <= chk_dis_reg;
                        avs_readdata[`EPT_PCTL_INJ] <= inject_reg;
                        avs_readdata[`EPT_PCTL_LEN_HI:`EPT_PCTL_LEN_LO] <= inj_len_reg;
                    end
                    `EPT_OFS_STS: avs_readdata[`EPT_STS_FLAG] <= flag_reg;
                    `EPT_OFS_CNT: avs_readdata[CNT_W-1:0] <= cnt_reg;
                    `EPT_OFS_RCTL: avs_readdata[1:0] <= rep_ctl_reg;
                    default: avs_readdata <= '0;
                endcase
            end
        end
    end

    //------------------------------------------------------------
    // ingress: parity generation, injection, attribute forcing
    //------------------------------------------------------------
    logic s1_valid;
    logic s1_sop;
    logic s1_eop;
    logic [31:0] s1_data;
    logic s1_par;
    logic s1_app;
    logic inj_pkt_reg;
    logic inj_now;
    logic [31:0] mod_data;

    // length lives in the first dword, so the match is known on sop
    assign inj_now = rx_sop ? (inject_reg && rx_data[`EPT_HDR_LEN_HI:0] == inj_len_reg)
                            : inj_pkt_reg;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            inj_pkt_reg <= 1'b0;
            rx_retry_req <= 1'b0;
        end
        else
        begin
            if (rx_valid && rx_sop)
                inj_pkt_reg <= inj_now;
            rx_retry_req <= rx_valid & rx_eop & rx_lcrc_bad;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s1_valid <= 1'b0;
            s1_sop <= 1'b0;
            s1_eop <= 1'b0;
            s1_data <= '0;
            s1_par <= 1'b0;
            s1_app <= 1'b0;
        end
        else
        begin
            s1_valid <= rx_valid;
            s1_sop <= rx_sop;
            s1_eop <= rx_eop;
            s1_data <= rx_data;
            s1_par <= (^rx_data) ^ inj_now;
            s1_app <= attr_ok(rx_data);
        end
    end

    always_comb
    begin
        mod_data = s1_data;
        if (s1_sop && s1_app && fro_reg)
            mod_data[`EPT_HDR_RO] = rov_reg;
        if (s1_sop && s1_app && fns_reg)
            mod_data[`EPT_HDR_NS] = nsv_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ig_valid <= 1'b0;
            ig_sop <= 1'b0;
            ig_eop <= 1'b0;
            ig_data <= '0;
            ig_par <= 1'b0;
        end
        else
        begin
            ig_valid <= s1_valid;
            ig_sop <= s1_sop;
            ig_eop <= s1_eop;
            ig_data <= mod_data;
            // parity carried with the dword into core storage
            ig_par <= s1_par ^ (^(mod_data ^ s1_data));
        end
    end

    //------------------------------------------------------------
    // produced tlps and consumed tlps
    //------------------------------------------------------------
    logic cs_bad_reg;
    logic cs_err;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            gp_valid <= 1'b0;
            gp_sop <= 1'b0;
            gp_eop <= 1'b0;
            gp_data <= '0;
            gp_par <= 1'b0;
        end
        else
        begin
            gp_valid <= gn_valid;
            gp_sop <= gn_sop;
            gp_eop <= gn_eop;
            gp_data <= gn_data;
            gp_par <= ^gn_data;
        end
    end

    assign cs_err = cs_valid & ~chk_dis_reg & ((^cs_data) ^ cs_par);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cs_bad_reg <= 1'b0;
            cs_drop <= 1'b0;
        end
        else
        begin
            if (cs_valid)
                cs_bad_reg <= cs_eop ? 1'b0 : (cs_bad_reg | cs_err);
            cs_drop <= cs_valid & cs_eop & (cs_bad_reg | cs_err);
        end
    end

    //------------------------------------------------------------
    // egress: parity check alongside lcrc, nullify on error
    //------------------------------------------------------------
    ept_eg_state_e eg_state_reg;
    logic [31:0] crc_reg;
    logic [31:0] crc_next;
    logic eg_bad_reg;
    logic eg_err;
    logic eg_pkt_bad;

    assign crc_next = crc_dw(eg_sop ? `EPT_CRC_SEED : crc_reg, eg_data);
    assign eg_err = eg_valid & ~chk_dis_reg & ((^eg_data) ^ eg_par);
    assign eg_pkt_bad = (eg_bad_reg & ~eg_sop & (eg_state_reg == EPT_EG_PKT)) | eg_err;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            eg_state_reg <= EPT_EG_IDLE;
            crc_reg <= `EPT_CRC_SEED;
            eg_bad_reg <= 1'b0;
        end
        else
        begin
            case (eg_state_reg)
                EPT_EG_IDLE:
                    if (eg_valid && eg_sop && !eg_eop)
                        eg_state_reg <= EPT_EG_PKT;
                EPT_EG_PKT:
                    if (eg_valid && eg_eop)
                        eg_state_reg <= EPT_EG_IDLE;
                default: eg_state_reg <= EPT_EG_IDLE;
            endcase
            if (eg_valid)
            begin
                crc_reg <= crc_next;
                eg_bad_reg <= eg_pkt_bad;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            tx_valid <= 1'b0;
            tx_sop <= 1'b0;
            tx_eop <= 1'b0;
            tx_data <= '0;
            tx_lcrc <= '0;
            tx_edb <= 1'b0;
        end
        else
        begin
            tx_valid <= eg_valid;
            tx_sop <= eg_sop;
            tx_eop <= eg_eop;
            tx_data <= eg_data;
            tx_lcrc <= '0;
            tx_edb <= 1'b0;
            if (eg_valid && eg_eop)
            begin
                // normal lcrc is the complemented remainder; nullify sends its inverse
                tx_lcrc <= eg_pkt_bad ? crc_next : ~crc_next;
                tx_edb <= eg_pkt_bad;
            end
        end
    end

    //------------------------------------------------------------
    // error status, counter and message
    //------------------------------------------------------------
    assign err_evt = (eg_valid & eg_eop & eg_pkt_bad)
                   | (cs_valid & cs_eop & (cs_bad_reg | cs_err));

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            flag_reg <= 1'b0;
        else if (err_evt)
            flag_reg <= 1'b1;
        else if (sts_clr)
            flag_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            cnt_reg <= '0;
        else if (cnt_rd)
            cnt_reg <= err_evt ? CNT_W'(1) : '0;
        else if (err_evt && cnt_reg != {CNT_W{1'b1}})
            cnt_reg <= cnt_reg + CNT_W'(1);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            err_msg_valid <= 1'b0;
            err_msg_type <= `EPT_REP_NONE;
        end
        else
        begin
            err_msg_valid <= err_evt & ~flag_reg
                & (rep_ctl_reg != `EPT_REP_NONE);
            if (err_evt && !flag_reg)
                err_msg_type <= rep_ctl_reg;
        end
    end

endmodule

/* File: common/ept_defines.svh */
// register map, field positions, reset values and tlp codes
`ifndef EPT_DEFINES_SVH
`define EPT_DEFINES_SVH
`define EPT_OFS_PCTL 4'h0
`define EPT_OFS_STS 4'h4
`define EPT_OFS_CNT 4'h8
`define EPT_OFS_RCTL 4'hC
`define EPT_OFS_ACTL 4'h0
`define EPT_PAGE_ATTR 1'b1
`define EPT_PCTL_DIS 0
`define EPT_PCTL_INJ 1
`define EPT_PCTL_LEN_LO 16
`define EPT_PCTL_LEN_HI 25
`define EPT_STS_FLAG 0
`define EPT_ACTL_FRO 0
`define EPT_ACTL_ROV 1
`define EPT_ACTL_FNS 2
`define EPT_ACTL_NSV 3
`define EPT_RCTL_RST 2'h2
`define EPT_REP_NONE 2'h0
`define EPT_REP_COR 2'h1
`define EPT_REP_NF 2'h2
`define EPT_REP_FAT 2'h3
`define EPT_HDR_LEN_HI 9
`define EPT_HDR_RO 13
`define EPT_HDR_NS 12
`define EPT_HDR_TYPE_HI 28
`define EPT_HDR_TYPE_LO 25
`define EPT_TYPE_MEM 4'h0
`define EPT_TYPE_CPL 4'h5
`define EPT_CRC_POLY 32'h04C1_1DB7
`define EPT_CRC_SEED 32'hFFFF_FFFF
`endif

/* File: common/ept_pkg.sv */
// types shared by the parity and attribute block
package ept_pkg;
    typedef enum logic [1:0] {
        EPT_EG_IDLE = 2'b01,
        EPT_EG_PKT = 2'b10
    } ept_eg_state_e;
    typedef logic [31:0] ept_dword_t;
endpackage

/* File: dv/ept_port_properties.sv */
// concurrent checks on the parity port, seen through its ports only
`timescale 1ns/100ps
module ept_port_properties
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // streams
    input wire logic rx_valid,
    input wire logic rx_sop,
    input wire logic rx_eop,
    input wire logic rx_lcrc_bad,
    input wire logic rx_retry_req,
    input wire logic ig_valid,
    input wire logic ig_sop,
    input wire logic ig_eop,
    input wire logic gn_valid,
    input wire logic [31:0] gn_data,
    input wire logic gn_sop,
    input wire logic gn_eop,
    input wire logic gp_valid,
    input wire logic [31:0] gp_data,
    input wire logic gp_par,
    input wire logic gp_sop,
    input wire logic gp_eop,
    input wire logic eg_valid,
    input wire logic eg_eop,
    input wire logic eg_sop,
    input wire logic [31:0] eg_data,
    input wire logic tx_valid,
    input wire logic tx_eop,
    input wire logic tx_sop,
    input wire logic [31:0] tx_data,
    input wire logic [31:0] tx_lcrc,
    input wire logic tx_edb,
    input wire logic cs_drop,
    input wire logic err_msg_valid,
    input wire logic [1:0] err_msg_type
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    retry_req_a:
        assert property (rx_valid && rx_eop && rx_lcrc_bad |=> rx_retry_req)
        else $error("no retry after bad lcrc");
    ig_timing_a:
        assert property (rx_valid |-> ##2 ig_valid && ig_sop == $past(rx_sop, 2)
            && ig_eop == $past(rx_eop, 2))
        else $error("ingress beat late or lost");
    gp_frame_a:
        assert property (gn_valid |=> gp_sop == $past(gn_sop) && gp_eop == $past(gn_eop))
        else $error("generated frame marks wrong");
    tx_follow_a:
        assert property (eg_valid |=> tx_sop == $past(eg_sop) && tx_data == $past(eg_data))
        else $error("egress dword not forwarded");
    gen_parity_a:
        assert property (gn_valid |=> gp_valid && gp_par == ^gp_data
            && gp_data == $past(gn_data))
        else $error("generated dword parity wrong");
    tx_end_a:
        assert property (eg_valid && eg_eop |=> tx_valid && tx_eop)
        else $error("egress end not forwarded");
    lcrc_idle_a:
        assert property (!tx_eop |-> tx_lcrc == 32'h0000_0000 && !tx_edb)
        else $error("lcrc or edb outside packet end");
    msg_cause_a:
        assert property (err_msg_valid |-> tx_edb || cs_drop)
        else $error("error message without parity error");
    msg_once_a:
        assert property (err_msg_valid |=> !err_msg_valid)
        else $error("error message repeated");
    msg_type_a:
        assert property (err_msg_valid |-> err_msg_type != 2'h0)
        else $error("error message with no type");
    wait_one_a:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    cover property (tx_edb);
    cover property (err_msg_valid);
    cover property (cs_drop);
    cover property (rx_retry_req);
endmodule

/* File: dv/ept_link_partner.sv */
// link partner model: takes transmitted tlps, drops nullified ones
`timescale 1ns/100ps
module ept_link_partner
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // transmit stream
    input wire logic tx_valid,
    input wire logic tx_eop,
    input wire logic tx_edb,
    // packet tallies
    output int n_ok,
    output int n_null
);
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            n_ok <= 0;
            n_null <= 0;
        end
        else if (tx_valid && tx_eop && tx_edb)
            n_null <= n_null + 1;
        else if (tx_valid && tx_eop)
            n_ok <= n_ok + 1;
    end
endmodule

/* File: dv/switch_tlp_parity_and_attr_mod_tb_top.sv */
// self-checking bench for the parity and attribute port
`timescale 1ns/100ps
`include "ept_defines.svh"
module switch_tlp_parity_and_attr_mod_tb_top;
    logic clk_sys, sys_rst, avs_read, avs_write, v, s, e, p, bad;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, d, avs_readdata, ig_data, gp_data, tx_lcrc;
    logic [1:0] sel, err_msg_type;
    logic avs_waitrequest, rx_retry_req, ig_valid, ig_par, gp_valid, gp_par;
    logic cs_drop, tx_valid, tx_eop, tx_edb, err_msg_valid;
    logic flag_m = 0, dis_m = 0, inj_m = 0;
    logic [1:0] rep_m = 2'h2;
    logic [3:0] attr_m = 4'h0;
    logic [9:0] len_m = 10'h000;
    logic [32:0] q_ig[$], q_gp[$], q_tx[$], q_rd[$], q_ev[$];
    int miscompares = 0, n_tests = 0, n_ok, n_null;
    ept_port i_ept_port (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_valid(v && sel == 2'd0), .rx_sop(s), .rx_eop(e), .rx_data(d),
        .rx_lcrc_bad(bad), .rx_retry_req(rx_retry_req), .ig_valid(ig_valid),
        .ig_sop(), .ig_eop(), .ig_data(ig_data), .ig_par(ig_par),
        .gn_valid(v && sel == 2'd3), .gn_sop(s), .gn_eop(e), .gn_data(d),
        .gp_valid(gp_valid), .gp_sop(), .gp_eop(), .gp_data(gp_data), .gp_par(gp_par),
        .cs_valid(v && sel == 2'd2), .cs_eop(e), .cs_data(d), .cs_par(p),
        .cs_drop(cs_drop), .eg_valid(v && sel == 2'd1), .eg_sop(s), .eg_eop(e),
        .eg_data(d), .eg_par(p), .tx_valid(tx_valid), .tx_sop(), .tx_eop(tx_eop),
        .tx_data(), .tx_lcrc(tx_lcrc), .tx_edb(tx_edb),
        .err_msg_valid(err_msg_valid), .err_msg_type(err_msg_type));
    ept_link_partner i_partner (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .tx_valid(tx_valid), .tx_eop(tx_eop), .tx_edb(tx_edb), .n_ok(n_ok),
        .n_null(n_null));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [32:0] sv, input logic [32:0] xv);
        n_tests++;
        if (sv !== xv)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, sv, xv);
        end
    endtask
    task automatic report_and_stop;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [32:0] pop(ref logic [32:0] q[$]);
        return q.size() ? q.pop_front() : 'x;
    endfunction
    function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? `EPT_CRC_POLY : 32'h0);
        return c;
    endfunction
    function automatic logic [32:0] ig_exp(input logic [31:0] w, input logic h,
        input logic [9:0] len);
        logic ap;
        ap = h && (w[`EPT_HDR_TYPE_HI:`EPT_HDR_TYPE_LO] inside {`EPT_TYPE_MEM, `EPT_TYPE_CPL});
        if (ap && attr_m[0])
            w[`EPT_HDR_RO] = attr_m[1];
        if (ap && attr_m[2])
            w[`EPT_HDR_NS] = attr_m[3];
        return {^w ^ (inj_m && len == len_m), w};
    endfunction
    task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_write <= we;
        avs_read <= !we;
        avs_address <= a;
        avs_writedata <= wd;
        do
            @(posedge clk_sys);
        while (avs_waitrequest);
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] x);
        q_rd.push_back({1'b0, x});
        bus(0, a, 0);
    endtask
    // pt: 0 ingress, 1 egress, 2 consumed, 3 generated; bi: dword with bad parity
    task automatic pkt(input int pt, input logic [3:0] ty, input logic [9:0] len,
        input int n, input int bi, input logic lb);
        logic [31:0] w;
        logic [31:0] c;
        logic bp;
        c = `EPT_CRC_SEED;
        bp = 0;
        for (int i = 0; i < n; i++)
        begin
            w = i ? $urandom : {3'h0, ty, 15'h0, len};
            @(posedge clk_sys);
            sel <= 2'(pt);
            v <= 1;
            s <= i == 0;
            e <= i == n - 1;
            d <= w;
            p <= ^w ^ (i == bi);
            bad <= lb && i == n - 1;
            c = crc(c, w);
            bp = bp | (i == bi);
            if (pt == 0)
                q_ig.push_back(ig_exp(w, i == 0, len));
            if (pt == 3)
                q_gp.push_back({^w, w});
        end
        @(posedge clk_sys);
        v <= 0;
        bad <= 0;
        if (pt == 0 && lb)
            q_ev.push_back(33'h30);
        if (pt == 1)
            q_tx.push_back({bp && !dis_m, (bp && !dis_m) ? c : ~c});
        if (bp && !dis_m && pt inside {1, 2})
        begin
            if (!flag_m && rep_m != 0)
                q_ev.push_back({31'h4, rep_m});
            if (pt == 2)
                q_ev.push_back(33'h20);
            flag_m = 1;
        end
    endtask
    // ------------------------------------------------------------
    // clock, monitor, watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (ig_valid)
            chk({ig_par, ig_data}, pop(q_ig));
        if (gp_valid)
            chk({gp_par, gp_data}, pop(q_gp));
        if (tx_valid && tx_eop)
            chk({tx_edb, tx_lcrc}, pop(q_tx));
        if (avs_read && !avs_waitrequest)
            chk({1'b0, avs_readdata}, pop(q_rd));
        if (err_msg_valid)
            chk({31'h4, err_msg_type}, pop(q_ev));
        if (cs_drop)
            chk(33'h20, pop(q_ev));
        if (rx_retry_req)
            chk(33'h30, pop(q_ev));
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hb740));
        {sys_rst, avs_read, avs_write, v, s, e, p, bad} = 8'h80;
        avs_address = 0;
        avs_writedata = 0;
        d = 0;
        sel = 0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 0;
        for (int i = 0; i < 6; i++)
            rd(i == 4 ? 5'd16 : 5'(i), i == 3 ? 32'h2 : 32'h0);
        pkt(0, 0, 4, 4, -1, 0);
        pkt(0, 0, 2, 2, -1, 1);
        bus(1, 0, 32'h0003_0002);
        inj_m = 1;
        len_m = 3;
        pkt(0, 0, 3, 3, -1, 0);
        pkt(0, 0, 5, 2, -1, 0);
        bus(1, 16, 32'h0000_0003);
        attr_m = 4'h3;
        pkt(0, 0, 3, 3, -1, 0);
        bus(1, 0, 0);
        inj_m = 0;
        bus(1, 16, 32'h0000_000f);
        attr_m = 4'hf;
        for (int t = 0; t < 16; t++)
            pkt(0, 4'(t), 1, 1, -1, 0);
        bus(1, 16, 0);
        attr_m = 0;
        pkt(3, 0, 3, 3, -1, 0);
        pkt(1, 0, 4, 4, -1, 0);
        pkt(1, 0, 4, 4, 2, 0);
        pkt(1, 0, 1, 1, 0, 0);
        rd(1, 1);
        rd(2, 2);
        rd(2, 0);
        for (int i = 0; i < 256; i++)
            pkt(1, 0, 1, 1, 0, 0);
        rd(2, 32'h0000_00ff);
        pkt(2, 0, 2, 2, 1, 0);
        for (int r = 0; r < 4; r++)
        begin
            bus(1, 3, 32'(r));
            bus(1, 1, 1);
            rep_m = 2'(r);
            flag_m = 0;
            pkt(1, 0, 2, 2, 0, 0);
        end
        bus(1, 0, 1);
        dis_m = 1;
        pkt(1, 0, 2, 2, 1, 0);
        pkt(2, 0, 2, 2, 1, 0);
        repeat (6) @(posedge clk_sys);
        chk(q_ig.size() + q_tx.size() + q_ev.size() + q_gp.size() + q_rd.size(), 0);
        chk(n_null, 262);
        chk(n_ok, 2);
        report_and_stop();
    end
endmodule
bind ept_port ept_port_properties i_ept_port_properties (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_sop(rx_sop),
    .rx_eop(rx_eop), .rx_lcrc_bad(rx_lcrc_bad), .rx_retry_req(rx_retry_req),
    .ig_valid(ig_valid), .ig_sop(ig_sop), .ig_eop(ig_eop), .gn_valid(gn_valid),
    .gn_data(gn_data), .gn_sop(gn_sop), .gn_eop(gn_eop), .gp_valid(gp_valid),
    .gp_data(gp_data), .gp_par(gp_par), .gp_sop(gp_sop), .gp_eop(gp_eop),
    .eg_valid(eg_valid), .eg_eop(eg_eop), .eg_sop(eg_sop), .eg_data(eg_data),
    .tx_valid(tx_valid), .tx_eop(tx_eop), .tx_sop(tx_sop), .tx_data(tx_data),
    .tx_lcrc(tx_lcrc),
    .tx_edb(tx_edb), .cs_drop(cs_drop), .err_msg_valid(err_msg_valid),
    .err_msg_type(err_msg_type));
